// file: include/pac_pkg.sv
//
// Contract
// - Fast flash 120 per minute, equal halves.
// - Trouble flash 20 per minute, equal halves.
// - Buzzer steady alarm, fast supervisory, slow trouble.
// - Option: building monitor sounds buzzer slowly.
// - Buzzer stops when non-latching cause clears.
// - Mains lamp lit only while mains good.
// - Alarm lamp flashes, steady when reviewed, till reset.
// - Supervisory lamp fast flash, steady acknowledged, off cleared.
// - Trouble lamp slow flash, steady reviewed, off cleared.
// - Monitor lamp slow flash while condition active.
// - Processor fault lamp slow flash when flagged.
// - Cancel lamp fast timing, steady cancelled, off expired.
// - Second stage lamp steady until reset.
// - Silence lamp slow flash while outputs silenced.
// - Ground fault lamp slow flash, off when clear.
// - Queues ranked alarm, supervisory, trouble, monitor.
// - Queue selection reverts after ten idle seconds.
// - Reset clears latches, outputs, drill, timers.
// - Reset ignored while silence inhibit runs.
// - Silence drops silenceable outputs; new alarm resounds.
// - Silence ignored during inhibit or drill.
// - Before timer expiry silence also cancels.
// - Drill drives configured outputs, no tie or relay.
// - Drill button toggles; real alarm cancels; lamp steady.
//
package pac_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int FAST_PER_MIN = 120;
    localparam int SLOW_PER_MIN = 20;
    localparam int SEC_PER_MIN = 60;
    // Half period of each pattern, in clock cycles.
    localparam int FAST_HALF = CLK_HZ * SEC_PER_MIN / FAST_PER_MIN / 2;
    localparam int SLOW_HALF = CLK_HZ * SEC_PER_MIN / SLOW_PER_MIN / 2;
    localparam int IDLE_S = 10;
    localparam int IDLE_CYC = CLK_HZ * IDLE_S;
    localparam int CW = 32;
    localparam int NOUT = 8;
    localparam logic [1:0] Q_ALARM = 2'h0;
    localparam logic [1:0] Q_SUPV = 2'h1;
    localparam logic [1:0] Q_TRBL = 2'h2;
    localparam logic [1:0] Q_MON = 2'h3;
    localparam logic [NOUT-1:0] DRILL_MASK_RST = 8'hFF;
    typedef enum logic [3:0] {
        GT_IDLE = 4'h1,
        GT_RUN = 4'h2,
        GT_CANCEL = 4'h4,
        GT_EXPIRED = 4'h8
    } pac_gt_e;
endpackage

// file: rtl/pac_top.sv
`timescale 1ns/1ns
module pac_top #(
    parameter int FAST_HALF_CYC = pac_pkg::FAST_HALF,
    parameter int SLOW_HALF_CYC = pac_pkg::SLOW_HALF,
    parameter int IDLE_TIMEOUT_CYC = pac_pkg::IDLE_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_in,
    input wire logic supv_latch_in,
    input wire logic supv_nonlatch_in,
    input wire logic trbl_latch_in,
    input wire logic trbl_nonlatch_in,
    input wire logic building_monitor_in,
    input wire logic cpu_fault_in,
    input wire logic ground_fault_in,
    input wire logic mains_ok_in,
    input wire logic ga_circuit_in,
    input wire logic gt_expire_in,
    input wire logic inhibit_run_in,
    input wire logic auto_silence_in,
    input wire logic btn_reset,
    input wire logic btn_silence,
    input wire logic btn_drill,
    input wire logic btn_second_stage,
    input wire logic btn_cancel,
    input wire logic btn_queue,
    input wire logic btn_ack_alarm,
    input wire logic btn_ack_supv,
    input wire logic btn_ack_trbl,
    output logic buzzer,
    output logic led_mains,
    output logic led_alarm,
    output logic led_supv,
    output logic led_trbl,
    output logic led_mon,
    output logic led_cpu,
    output logic led_drill,
    output logic led_cancel,
    output logic led_second_stage,
    output logic led_silence,
    output logic led_ground,
    output logic [1:0] queue_sel,
    output logic [pac_pkg::NOUT-1:0] notification_output,
    output logic city_tie,
    output logic alarm_relay,
    output logic supply_cycle,
    output logic gt_timer_run,
    output logic gt_timer_clear
);
    localparam logic [11:0] A_CFG = 12'h000;
    localparam logic [11:0] A_MAP = 12'h004;
    localparam logic [11:0] A_DRL = 12'h008;
    localparam logic [11:0] A_STS = 12'h00C;
    localparam int B_TWO = 0;
    localparam int B_MONBZ = 1;
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Three stages; a level is accepted once stages two and three agree.
    localparam int NI = 24;
    logic [NI-1:0] raw;
    logic [NI-1:0] s1_ff, s2_ff, s3_ff, in_ff;
    logic [NI-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_in;
    assign raw = {btn_ack_trbl, btn_ack_supv, btn_ack_alarm, btn_queue, btn_cancel,
                  btn_second_stage, btn_drill, btn_silence, btn_reset, auto_silence_in,
                  inhibit_run_in, gt_expire_in, ga_circuit_in, mains_ok_in, ground_fault_in,
                  cpu_fault_in, building_monitor_in, trbl_nonlatch_in, trbl_latch_in,
                  supv_nonlatch_in, supv_latch_in, alarm_in, 1'b0, 1'b0};
    always_comb begin
        nxt_s1 = raw;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        nxt_in = in_ff;
        for (int i = 0; i < NI; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_in[i] = s3_ff[i];
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            in_ff <= '0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            in_ff <= nxt_in;
        end
    end
    logic i_alm, i_sl, i_sn, i_tl, i_tn, i_mon, i_cpu, i_gnd, i_ac, i_gac, i_gexp, i_inh;
    logic i_asil;
    assign {i_asil, i_inh, i_gexp, i_gac, i_ac, i_gnd, i_cpu, i_mon, i_tn, i_tl, i_sn, i_sl,
            i_alm} = in_ff[14:2];
    // Buttons act on their press edge only.
    logic [21:0] bprev_ff, nxt_bprev;
    logic [8:0] bp;
    assign nxt_bprev = in_ff[23:2];
    assign bp = in_ff[23:15] & ~bprev_ff[21:13];
    logic p_rst, p_sil, p_drl, p_ss, p_can, p_q, p_aa, p_as, p_at;
    assign {p_at, p_as, p_aa, p_q, p_can, p_ss, p_drl, p_sil, p_rst} = bp;
    // ----------------------------------------------------------------
    // Flash prescaler
    // ----------------------------------------------------------------
    logic [31:0] fcnt_ff, scnt_ff, nxt_fcnt, nxt_scnt;
    logic fast_ff, slow_ff, nxt_fast, nxt_slow;
    always_comb begin
        nxt_fcnt = fcnt_ff + 32'h1;
        nxt_scnt = scnt_ff + 32'h1;
        nxt_fast = fast_ff;
        nxt_slow = slow_ff;
        if (fcnt_ff == 32'(FAST_HALF_CYC - 1)) begin
            nxt_fcnt = '0;
            nxt_fast = ~fast_ff;
        end
        if (scnt_ff == 32'(SLOW_HALF_CYC - 1)) begin
            nxt_scnt = '0;
            nxt_slow = ~slow_ff;
        end
    end
    // ----------------------------------------------------------------
    // Panel state
    // ----------------------------------------------------------------
    logic [31:0] cfg_ff, nxt_cfg;
    logic [pac_pkg::NOUT-1:0] map_ff, nxt_map, dmask_ff, nxt_dmask;
    logic alarm_ff, supvl_ff, trbll_ff, ga_ff, sil_ff, drill_ff, nxt_alarm, nxt_supvl;
    logic nxt_trbll, nxt_ga, nxt_sil, nxt_drill;
    logic arev_ff, srev_ff, trev_ff, nxt_arev, nxt_srev, nxt_trev;
    logic cyc_ff, nxt_cyc, clr_ff, nxt_clr;
    pac_pkg::pac_gt_e gt_ff, nxt_gt;
    logic [1:0] qsel_ff, nxt_qsel, best;
    logic [31:0] idle_ff, nxt_idle;
    logic man_ff, nxt_man;
    logic two, supv_any, trbl_any, do_rst, new_alarm;
    assign two = cfg_ff[B_TWO];
    assign supv_any = supvl_ff | i_sn;
    assign trbl_any = trbll_ff | i_tn;
    assign do_rst = p_rst & ~i_inh;
    assign new_alarm = (i_alm | (two & (i_gac | p_ss))) & ~do_rst;
    always_comb begin
        nxt_alarm = alarm_ff | new_alarm;
        nxt_supvl = supvl_ff | i_sl;
        nxt_trbll = trbll_ff | i_tl;
        nxt_ga = ga_ff;
        nxt_sil = sil_ff;
        nxt_drill = drill_ff;
        nxt_gt = gt_ff;
        nxt_arev = arev_ff | p_aa;
        nxt_srev = (srev_ff | p_as) & supv_any;
        nxt_trev = (trev_ff | p_at) & trbl_any;
        nxt_cyc = 1'b0;
        nxt_clr = 1'b0;
        if (i_alm & ~alarm_ff) begin
            nxt_arev = 1'b0;
        end
        if (two & alarm_ff & (i_gac | p_ss | (gt_ff == pac_pkg::GT_RUN & i_gexp))) begin
            nxt_ga = 1'b1;
        end
        unique case (gt_ff)
            pac_pkg::GT_IDLE: begin
                if (two & alarm_ff & ~ga_ff) begin
                    nxt_gt = pac_pkg::GT_RUN;
                end
            end
            pac_pkg::GT_RUN: begin
                if (i_gexp | ga_ff) begin
                    nxt_gt = pac_pkg::GT_EXPIRED;
                end else if (p_can | p_sil) begin
                    nxt_gt = pac_pkg::GT_CANCEL;
                end
            end
            pac_pkg::GT_CANCEL: begin
                if (ga_ff) begin
                    nxt_gt = pac_pkg::GT_EXPIRED;
                end
            end
            pac_pkg::GT_EXPIRED: begin
                nxt_gt = pac_pkg::GT_EXPIRED;
            end
        endcase
        if (alarm_ff & ~i_inh & ~drill_ff & (p_sil | i_asil)) begin
            nxt_sil = 1'b1;
            if (gt_ff == pac_pkg::GT_EXPIRED) begin
                nxt_clr = 1'b1;
            end
        end
        if (new_alarm & alarm_ff & ((i_alm & ~bprev_ff[0]) | p_ss)) begin
            nxt_sil = 1'b0;
        end
        if (i_alm & ~alarm_ff) begin
            nxt_sil = 1'b0;
        end
        if (p_drl) begin
            nxt_drill = ~drill_ff;
        end
        if (nxt_alarm) begin
            nxt_drill = 1'b0;
        end
        if (do_rst) begin
            nxt_alarm = 1'b0;
            nxt_supvl = 1'b0;
            nxt_trbll = 1'b0;
            nxt_ga = 1'b0;
            nxt_sil = 1'b0;
            nxt_drill = 1'b0;
            nxt_gt = pac_pkg::GT_IDLE;
            nxt_arev = 1'b0;
            nxt_srev = 1'b0;
            nxt_trev = 1'b0;
            nxt_cyc = 1'b1;
            nxt_clr = 1'b1;
        end
    end
    // ----------------------------------------------------------------
    // Queue selection
    // ----------------------------------------------------------------
    always_comb begin
        best = pac_pkg::Q_MON;
        if (trbl_any) begin
            best = pac_pkg::Q_TRBL;
        end
        if (supv_any) begin
            best = pac_pkg::Q_SUPV;
        end
        if (alarm_ff) begin
            best = pac_pkg::Q_ALARM;
        end
        nxt_qsel = qsel_ff;
        nxt_man = man_ff;
        nxt_idle = idle_ff;
        if (p_q) begin
            nxt_qsel = qsel_ff + 2'h1;
            nxt_man = 1'b1;
            nxt_idle = '0;
        end else if (man_ff) begin
            nxt_idle = idle_ff + 32'h1;
            if (idle_ff == 32'(IDLE_TIMEOUT_CYC - 1)) begin
                nxt_man = 1'b0;
            end
        end
        if (!man_ff || best < qsel_ff) begin
            nxt_qsel = best;
            if (best < qsel_ff) begin
                nxt_man = 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic nxt_buz;
    logic [13:0] nxt_leds;
    logic [pac_pkg::NOUT-1:0] nxt_no;
    always_comb begin
        if (alarm_ff) begin
            nxt_buz = 1'b1;
        end else if (supv_any) begin
            nxt_buz = fast_ff;
        end else if (trbl_any | (cfg_ff[B_MONBZ] & i_mon)) begin
            nxt_buz = slow_ff;
        end else begin
            nxt_buz = 1'b0;
        end
        nxt_leds[0] = i_ac;
        nxt_leds[1] = alarm_ff & (arev_ff | fast_ff);
        nxt_leds[2] = supv_any & (srev_ff | fast_ff);
        nxt_leds[3] = trbl_any & (trev_ff | slow_ff);
        nxt_leds[4] = i_mon & slow_ff;
        nxt_leds[5] = i_cpu & slow_ff;
        nxt_leds[6] = drill_ff;
        nxt_leds[7] = two & ((gt_ff == pac_pkg::GT_RUN & fast_ff) |
                             gt_ff == pac_pkg::GT_CANCEL);
        nxt_leds[8] = two & ga_ff;
        nxt_leds[9] = sil_ff & slow_ff;
        nxt_leds[10] = i_gnd & slow_ff;
        nxt_leds[11] = alarm_ff & ~drill_ff;
        nxt_leds[13] = gt_ff == pac_pkg::GT_RUN;
        nxt_no = '0;
        if (alarm_ff) begin
            nxt_no = sil_ff ? ~map_ff : {pac_pkg::NOUT{1'b1}};
        end else if (drill_ff) begin
            nxt_no = dmask_ff;
        end
    end
    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic [31:0] nxt_prdata;
    logic nxt_pready, nxt_pslverr, acc;
    assign acc = psel & penable & ~pready;
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_map = map_ff;
        nxt_dmask = dmask_ff;
        nxt_pready = psel & penable & ~pready;
        nxt_pslverr = 1'b0;
        nxt_prdata = '0;
        if (acc) begin
            unique case (paddr)
                A_CFG: nxt_prdata = cfg_ff;
                A_MAP: nxt_prdata = {24'h0, map_ff};
                A_DRL: nxt_prdata = {24'h0, dmask_ff};
                A_STS: nxt_prdata = {18'h0, gt_ff, queue_sel, drill_ff, sil_ff, ga_ff,
                                     trbll_ff, supvl_ff, alarm_ff};
                default: nxt_pslverr = 1'b1;
            endcase
        end
        if (psel & penable & pready & pwrite) begin
            unique case (paddr)
                A_CFG: nxt_cfg = {30'h0, pwdata[1:0]};
                A_MAP: nxt_map = pwdata[pac_pkg::NOUT-1:0];
                A_DRL: nxt_dmask = pwdata[pac_pkg::NOUT-1:0];
                default: nxt_cfg = cfg_ff;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bprev_ff <= '0;
            fcnt_ff <= '0;
            scnt_ff <= '0;
            fast_ff <= 1'b0;
            slow_ff <= 1'b0;
            cfg_ff <= '0;
            map_ff <= '0;
            dmask_ff <= pac_pkg::DRILL_MASK_RST;
            alarm_ff <= 1'b0;
            supvl_ff <= 1'b0;
            trbll_ff <= 1'b0;
            ga_ff <= 1'b0;
            sil_ff <= 1'b0;
            drill_ff <= 1'b0;
            arev_ff <= 1'b0;
            srev_ff <= 1'b0;
            trev_ff <= 1'b0;
            cyc_ff <= 1'b0;
            clr_ff <= 1'b0;
            gt_ff <= pac_pkg::GT_IDLE;
            qsel_ff <= pac_pkg::Q_MON;
            idle_ff <= '0;
            man_ff <= 1'b0;
            buzzer <= 1'b0;
            {alarm_relay, city_tie, led_ground, led_silence, led_second_stage, led_cancel,
             led_drill, led_cpu, led_mon, led_trbl, led_supv, led_alarm, led_mains} <= '0;
            gt_timer_run <= 1'b0;
            notification_output <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            bprev_ff <= nxt_bprev;
            fcnt_ff <= nxt_fcnt;
            scnt_ff <= nxt_scnt;
            fast_ff <= nxt_fast;
            slow_ff <= nxt_slow;
            cfg_ff <= nxt_cfg;
            map_ff <= nxt_map;
            dmask_ff <= nxt_dmask;
            alarm_ff <= nxt_alarm;
            supvl_ff <= nxt_supvl;
            trbll_ff <= nxt_trbll;
            ga_ff <= nxt_ga;
            sil_ff <= nxt_sil;
            drill_ff <= nxt_drill;
            arev_ff <= nxt_arev;
            srev_ff <= nxt_srev;
            trev_ff <= nxt_trev;
            cyc_ff <= nxt_cyc;
            clr_ff <= nxt_clr;
            gt_ff <= nxt_gt;
            qsel_ff <= nxt_qsel;
            idle_ff <= nxt_idle;
            man_ff <= nxt_man;
            buzzer <= nxt_buz;
            {alarm_relay, city_tie, led_ground, led_silence, led_second_stage, led_cancel,
             led_drill, led_cpu, led_mon, led_trbl, led_supv, led_alarm, led_mains}
                <= {nxt_leds[11], nxt_leds[11], nxt_leds[10:0]};
            gt_timer_run <= nxt_leds[13];
            notification_output <= nxt_no;
            prdata <= nxt_prdata;
            pready <= nxt_pready;
            pslverr <= nxt_pslverr;
        end
    end
    assign queue_sel = qsel_ff;
    assign supply_cycle = cyc_ff;
    assign gt_timer_clear = clr_ff;
endmodule // pac_top

// file: verif/pac_top_asserts.sv
`timescale 1ns/1ns
module pac_top_asserts #(
    parameter int FAST_HALF_CYC = 4,
    parameter int SLOW_HALF_CYC = 12
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic alarm_in,
    input wire logic supv_nonlatch_in,
    input wire logic ground_fault_in,
    input wire logic mains_ok_in,
    input wire logic inhibit_run_in,
    input wire logic btn_reset,
    input wire logic btn_ack_supv,
    input wire logic buzzer,
    input wire logic led_mains,
    input wire logic led_supv,
    input wire logic led_ground,
    input wire logic led_second_stage,
    input wire logic led_silence,
    input wire logic [pac_pkg::NOUT-1:0] notification_output,
    input wire logic city_tie,
    input wire logic alarm_relay,
    input wire logic supply_cycle
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [15:0] g_len, s_len, rst_age, alm_age;
    logic [1:0] g_tg, s_tg;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            g_len <= 16'h0000;
            s_len <= 16'h0000;
            g_tg <= 2'h0;
            s_tg <= 2'h0;
            rst_age <= 16'hFFFF;
            alm_age <= 16'hFFFF;
        end else begin
            g_len <= $changed(led_ground) ? 16'h0001 : g_len + 16'h0001;
            s_len <= $changed(led_supv) ? 16'h0001 : s_len + 16'h0001;
            g_tg <= !ground_fault_in ? 2'h0 : g_tg + {1'b0, $changed(led_ground) && g_tg != 2'h2};
            s_tg <= !supv_nonlatch_in || btn_ack_supv ? 2'h0 :
                s_tg + {1'b0, $changed(led_supv) && s_tg != 2'h2};
            rst_age <= btn_reset ? 16'h0000 : rst_age + {15'h0000, rst_age != 16'hFFFF};
            alm_age <= alarm_in ? 16'h0000 : alm_age + {15'h0000, alm_age != 16'hFFFF};
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    mains_lamp_a: assert property ($stable(mains_ok_in) [*8] |-> led_mains == mains_ok_in)
        else $error("mains lamp wrong");
    slow_half_a: assert property ($changed(led_ground) && g_tg == 2'h2 |-> g_len == SLOW_HALF_CYC)
        else $error("slow half wrong");
    fast_half_a: assert property ($changed(led_supv) && s_tg == 2'h2 |-> s_len == FAST_HALF_CYC)
        else $error("fast half wrong");
    alarm_buzz_a: assert property ($rose(alarm_in) |-> ##[2:8] buzzer [*8])
        else $error("alarm buzzer off");
    stage_hold_a: assert property ($fell(led_second_stage) |-> rst_age < 16'h000C)
        else $error("stage lamp dropped");
    tie_cause_a: assert property ($rose(city_tie) || $rose(alarm_relay) |-> alm_age < 16'h000C)
        else $error("tie without alarm");
    reset_inhib_a: assert property (inhibit_run_in [*8] |-> !supply_cycle)
        else $error("reset during inhibit");
    reset_clear_a: assert property (supply_cycle && !alarm_in |->
        ##[0:4] (notification_output == 8'h00 && !led_silence))
        else $error("reset left outputs");
    ground_off_a: assert property (!ground_fault_in [*6] |-> !led_ground)
        else $error("ground lamp on");
endmodule // pac_top_asserts

// file: verif/pac_panel_model.sv
`timescale 1ns/1ns
module pac_panel_model (
    input wire logic sys_clk,
    output logic btn_reset,
    output logic btn_silence,
    output logic btn_drill,
    output logic btn_second_stage,
    output logic btn_cancel,
    output logic btn_queue,
    output logic btn_ack_alarm,
    output logic btn_ack_supv,
    output logic btn_ack_trbl
);
    // Momentary presses, held long enough to pass the input synchroniser.
    logic [8:0] held = 9'h000;
    assign {btn_ack_trbl, btn_ack_supv, btn_ack_alarm, btn_queue, btn_cancel} = held[8:4];
    assign {btn_second_stage, btn_drill, btn_silence, btn_reset} = held[3:0];
    task automatic press(input int b);
        @(posedge sys_clk);
        held[b] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        held[b] <= 1'b0;
    endtask
endmodule // pac_panel_model

// file: verif/tb_panel_annunciator_control.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_panel_annunciator_control;
    localparam int FH = 4;
    localparam int SH = 12;
    localparam int IDLE = 50;
    localparam int BZ = 0, MN = 1, AL = 2, SV = 3, TR = 4, MO = 5, CP = 6, GR = 7, SS = 8;
    localparam int CN = 9, SI = 10, DR = 11, PH = 12;
    localparam int B_RST = 0, B_SIL = 1, B_DRL = 2, B_GA = 3, B_CAN = 4, B_QUE = 5;
    localparam int B_AKA = 6, B_AKS = 7, B_AKT = 8;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, cycled;
    logic alarm_in = 1'b0, supv_nonlatch_in = 1'b0, trbl_nonlatch_in = 1'b0;
    logic building_monitor_in = 1'b0, cpu_fault_in = 1'b0, ground_fault_in = 1'b0;
    logic mains_ok_in = 1'b1, inhibit_run_in = 1'b0;
    logic btn_reset, btn_silence, btn_drill, btn_second_stage, btn_cancel, btn_queue;
    logic btn_ack_alarm, btn_ack_supv, btn_ack_trbl;
    logic buzzer, led_mains, led_alarm, led_supv, led_trbl, led_mon, led_cpu, led_drill;
    logic led_cancel, led_second_stage, led_silence, led_ground, city_tie, alarm_relay;
    logic supply_cycle, gt_timer_run, gt_timer_clear;
    logic [1:0] queue_sel;
    logic [pac_pkg::NOUT-1:0] notification_output, pre;
    int mismatches = 0;
    int compares = 0;
    wire [12:0] obs = {led_cpu ^ led_ground, led_drill, led_silence, led_cancel, led_second_stage,
        led_ground, led_cpu, led_mon, led_trbl, led_supv, led_alarm, led_mains, buzzer};
    // ------------------------------------------------------------
    // Design and panel
    // ------------------------------------------------------------
    pac_top #(.FAST_HALF_CYC(FH), .SLOW_HALF_CYC(SH), .IDLE_TIMEOUT_CYC(IDLE)) pac_top_i (.*,
        .supv_latch_in(1'b0), .trbl_latch_in(1'b0), .ga_circuit_in(1'b0), .gt_expire_in(1'b0),
        .auto_silence_in(1'b0));
    pac_panel_model pac_panel_model_i (.*);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (supply_cycle === 1'b1) cycled <= 1'b1;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic push(input int b);
        pac_panel_model_i.press(b);
        wt(8);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic flash(input int i, input int n, input int e, input string nm);
        int c;
        c = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (obs[i] === 1'b1) c++;
        end
        @(posedge sys_clk);
        `CHK(nm, e, c)
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(40000 * 100);
        mismatches++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        wt(16);
        nrst <= 1'b1;
        wt(10);
        apb(1'b0, 12'h008, 32'h00000000);
        `CHK("drill mask", 32'h000000FF, rd)
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b0, 12'h000, 32'h00000000);
        `CHK("cfg", 32'h00000003, rd)
        apb(1'b1, 12'h004, 32'h0000000F);
        flash(MN, 1, 1, "mains on");
        mains_ok_in <= 1'b0;
        wt(10);
        flash(MN, 1, 0, "mains off");
        mains_ok_in <= 1'b1;
        building_monitor_in <= 1'b1;
        wt(10);
        flash(BZ, 2 * SH, SH, "monitor buzzer");
        flash(MO, 2 * SH, SH, "monitor lamp");
        `CHK("queue monitor", pac_pkg::Q_MON, queue_sel)
        building_monitor_in <= 1'b0;
        trbl_nonlatch_in <= 1'b1;
        supv_nonlatch_in <= 1'b1;
        wt(10);
        flash(BZ, 2 * FH, FH, "fast wins");
        flash(SV, 4 * FH, 2 * FH, "supv flash");
        flash(TR, 2 * SH, SH, "trbl flash");
        flash(MO, 1, 0, "monitor off");
        supv_nonlatch_in <= 1'b0;
        wt(10);
        flash(BZ, 2 * SH, SH, "trouble buzzer");
        flash(SV, 1, 0, "supv off");
        trbl_nonlatch_in <= 1'b0;
        wt(10);
        flash(BZ, 2 * SH, 0, "buzzer stops");
        flash(TR, 1, 0, "trbl off");
        trbl_nonlatch_in <= 1'b1;
        supv_nonlatch_in <= 1'b1;
        wt(10);
        push(B_AKS);
        push(B_AKT);
        flash(SV, 2 * FH, 2 * FH, "supv reviewed");
        flash(TR, 2 * SH, 2 * SH, "trbl reviewed");
        trbl_nonlatch_in <= 1'b0;
        supv_nonlatch_in <= 1'b0;
        cpu_fault_in <= 1'b1;
        ground_fault_in <= 1'b1;
        wt(10);
        flash(CP, 2 * SH, SH, "cpu lamp");
        flash(GR, 2 * SH, SH, "ground lamp");
        flash(PH, 2 * SH, 0, "in phase");
        ground_fault_in <= 1'b0;
        cpu_fault_in <= 1'b0;
        wt(8);
        flash(GR, 1, 0, "ground off");
        building_monitor_in <= 1'b1;
        alarm_in <= 1'b1;
        wt(10);
        `CHK("queue alarm", pac_pkg::Q_ALARM, queue_sel)
        flash(BZ, 2 * FH, 2 * FH, "alarm buzzer");
        flash(AL, 2 * FH, FH, "alarm flash");
        flash(CN, 2 * FH, FH, "cancel flash");
        push(B_QUE);
        wt(IDLE + 20);
        `CHK("queue revert", pac_pkg::Q_ALARM, queue_sel)
        push(B_AKA);
        flash(AL, 2 * FH, 2 * FH, "alarm reviewed");
        push(B_CAN);
        flash(CN, 2 * FH, 2 * FH, "cancel steady");
        pre = notification_output;
        inhibit_run_in <= 1'b1;
        wt(8);
        push(B_SIL);
        flash(SI, 1, 0, "silence inhibited");
        inhibit_run_in <= 1'b0;
        wt(8);
        push(B_SIL);
        flash(SI, 2 * SH, SH, "silence flash");
        `CHK("silenced", 4'h0, notification_output[3:0])
        alarm_in <= 1'b0;
        wt(8);
        alarm_in <= 1'b1;
        wt(10);
        flash(SI, 1, 0, "resound lamp");
        `CHK("resound", pre, notification_output)
        push(B_GA);
        flash(SS, 1, 1, "second stage");
        alarm_in <= 1'b0;
        building_monitor_in <= 1'b0;
        inhibit_run_in <= 1'b1;
        wt(8);
        push(B_RST);
        flash(SS, 1, 1, "reset inhibited");
        inhibit_run_in <= 1'b0;
        cycled = 1'b0;
        wt(8);
        push(B_RST);
        wt(4);
        flash(SS, 1, 0, "stage cleared");
        flash(AL, 2 * FH, 0, "alarm cleared");
        `CHK("supply cycle", 1'b1, cycled)
        `CHK("outputs off", 8'h00, notification_output)
        apb(1'b1, 12'h008, 32'h000000A5);
        push(B_DRL);
        flash(DR, 2 * SH, 2 * SH, "drill lamp");
        `CHK("drill outputs", 8'hA5, notification_output)
        `CHK("drill tie", 1'b0, city_tie | alarm_relay)
        push(B_SIL);
        flash(SI, 1, 0, "drill silence");
        push(B_DRL);
        flash(DR, 1, 0, "drill toggled");
        push(B_DRL);
        alarm_in <= 1'b1;
        wt(10);
        flash(DR, 1, 0, "alarm ends drill");
        alarm_in <= 1'b0;
        wt(4);
        push(B_RST);
        wrap_up();
    end
endmodule // tb_panel_annunciator_control
bind pac_top pac_top_asserts #(.FAST_HALF_CYC(FAST_HALF_CYC), .SLOW_HALF_CYC(SLOW_HALF_CYC))
    pac_top_asserts_i (.*);
